// ---- hw/chirp_ctrl.sv ----
// Chirp and binary phase keying control of a direct digital synthesiser
`timescale 1ns/1ps
`include "chirp_cfg.svh"

// Notes on behaviour
// - Chirp sweep starts from the 48-bit start tuning word, bytes 0x04 to 0x09.
// - A 48-bit signed step word at 0x10 to 0x15 is added on every tick.
// - A 20-bit ramp rate count at 0x1A to 0x1C sets the dwell per frequency.
// - Written chirp settings take effect only on an update pulse.
// - Step word sign picks direction: MSB set sweeps down, clear sweeps up.
// - Sweep has no end point and no return; it wraps until stopped.
// - Frequency clear bit clears the accumulator for one clock; step word untouched.
// - While frequency clear bit stays set, every update edge restarts the sweep.
// - Full clear bit holds both accumulators at zero until software clears it.
// - Writes during full clear are kept and apply when the sweep resumes.
// - In chirp mode a high freeze pin stops the ramp counter and frequency.
// - After a freeze the counter finishes its old count before loading a new rate.
// - The 32-bit automatic update counter runs at half the system clock rate.
// - An all-zero step word leaves the frequency unchanged.
// - In keying mode the pin picks phase offset one (low) or two (high).
// - Ticks come from a down-counter from N, spaced N+1 clocks apart.
// - After reset the update clock is internal; clearing the bit makes it external.
module chirp_ctrl
    import chirp_pkg::*;
#(
    parameter int FW = 48,
    parameter int RW = 20,
    parameter int UW = 32,
    parameter int PW = 14
) (
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    input  wire logic [5:0]    par_addr_i,
    input  wire logic [7:0]    par_wdata_i,
    input  wire logic          par_wr_i,
    output logic      [7:0]    par_rdata_o,
    input  wire logic          update_i,
    output logic               update_o,
    output logic               update_oe_o,
    input  wire logic          mode_pin_i,
    output logic      [FW-1:0] freq_word_o,
    output logic      [PW-1:0] phase_o
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [FW-1:0] buf_ftw;
        logic [FW-1:0] buf_step;
        logic [RW-1:0] buf_ramp;
        logic [UW-1:0] buf_upd;
        logic [PW-1:0] buf_ph1;
        logic [PW-1:0] buf_ph2;
        ctrl_t         ctrl;
        logic [FW-1:0] act_ftw;
        logic [FW-1:0] act_step;
        logic [RW-1:0] act_ramp;
        logic [PW-1:0] act_ph1;
        logic [PW-1:0] act_ph2;
        logic [FW-1:0] facc;
        logic [FW-1:0] pacc;
        logic [FW-1:0] freq_out;
        logic [PW-1:0] phase_out;
        logic [7:0]    rdata;
        logic          wr_d;
        logic          ext_d;
        logic          half;
        logic [UW-1:0] ucnt;
        logic [3:0]    uhigh;
        logic          upd_pin;
        logic          clr1_d;
        logic          clr1_pulse;
    } st_t;

    st_t         st_reg;
    st_t         st_next;
    logic [2:0]  pins;
    logic        tick;
    logic        chirp;
    logic        bpsk;
    logic        hold;
    logic        run;
    logic        upd_evt;
    logic        int_evt;
    host_wr_t    wr;
    logic        wr_evt;

    // ==========================================================
    // Pin synchronisers and ramp tick generator
    pin_sync #(.W(3)) u_sync (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .pin_i   ({par_wr_i, update_i, mode_pin_i}),
        .level_o (pins)
    );

    ramp_tick #(.RW(RW)) u_tick (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .rate_i (st_reg.act_ramp),
        .run_i  (run),
        .tick_o (tick)
    );

    // ==========================================================
    // Mode decode and event detection
    always_comb begin
        chirp   = (st_reg.ctrl.mode == MODE_CHIRP);
        bpsk    = (st_reg.ctrl.mode == MODE_BPSK);
        hold    = chirp && pins[0];
        run     = chirp && !hold && !st_reg.ctrl.full_accum_clear_bit;
        int_evt = st_reg.half && (st_reg.ucnt == '0);
        upd_evt = st_reg.ctrl.int_update ? int_evt : (pins[1] && !st_reg.ext_d);
        wr_evt  = pins[2] && !st_reg.wr_d;
        wr.addr = par_addr_i;
        wr.data = par_wdata_i;
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_next       = st_reg;
        st_next.wr_d  = pins[2];
        st_next.ext_d = pins[1];

        // Host writes land in the buffer registers, also during full clear
        if (wr_evt) begin
            for (int i = 0; i < 6; i++) begin
                if (wr.addr == `OFS_FTW + 6'(i)) begin
                    st_next.buf_ftw[FW-1-8*i -: 8] = wr.data;
                end
                if (wr.addr == `OFS_STEP + 6'(i)) begin
                    st_next.buf_step[FW-1-8*i -: 8] = wr.data;
                end
            end
            for (int i = 0; i < 4; i++) begin
                if (wr.addr == `OFS_UPD + 6'(i)) begin
                    st_next.buf_upd[UW-1-8*i -: 8] = wr.data;
                end
            end
            if (wr.addr == `OFS_RAMP) begin
                st_next.buf_ramp[RW-1 -: 4] = wr.data[3:0];
            end else if (wr.addr == `OFS_RAMP + 6'h01) begin
                st_next.buf_ramp[15:8] = wr.data;
            end else if (wr.addr == `OFS_RAMP + 6'h02) begin
                st_next.buf_ramp[7:0] = wr.data;
            end else if (wr.addr == `OFS_PH1) begin
                st_next.buf_ph1[PW-1:8] = wr.data[5:0];
            end else if (wr.addr == `OFS_PH1 + 6'h01) begin
                st_next.buf_ph1[7:0] = wr.data;
            end else if (wr.addr == `OFS_PH2) begin
                st_next.buf_ph2[PW-1:8] = wr.data[5:0];
            end else if (wr.addr == `OFS_PH2 + 6'h01) begin
                st_next.buf_ph2[7:0] = wr.data;
            end else if (wr.addr == `OFS_CTRL) begin
                st_next.ctrl = ctrl_t'(wr.data);
            end
        end

        // Internal update counter at half the system rate
        st_next.half = !st_reg.half;
        if (st_reg.half) begin
            if (st_reg.ucnt == '0) begin
                st_next.ucnt = st_reg.buf_upd;
            end else begin
                st_next.ucnt = st_reg.ucnt - 1'b1;
            end
        end
        if (st_reg.ctrl.int_update && int_evt) begin
            st_next.uhigh = `UPD_HIGH_CYC;
        end else if (st_reg.uhigh != '0) begin
            st_next.uhigh = st_reg.uhigh - 1'b1;
        end
        st_next.upd_pin = st_next.uhigh != '0;

        // Buffers become active only on an update
        if (upd_evt) begin
            st_next.act_ftw  = st_reg.buf_ftw;
            st_next.act_step = st_reg.buf_step;
            st_next.act_ramp = st_reg.buf_ramp;
            st_next.act_ph1  = st_reg.buf_ph1;
            st_next.act_ph2  = st_reg.buf_ph2;
        end

        // One-clock clear on a new set and on every update while set
        st_next.clr1_d     = st_reg.ctrl.freq_accum_clear_bit;
        st_next.clr1_pulse = st_reg.ctrl.freq_accum_clear_bit &&
                             (!st_reg.clr1_d || upd_evt);

        // Frequency accumulator
        if (!chirp || st_reg.ctrl.full_accum_clear_bit) begin
            st_next.facc = '0;
        end else if (st_reg.clr1_pulse) begin
            st_next.facc = '0;
        end else if (tick && run) begin
            st_next.facc = st_reg.facc + st_reg.act_step;
        end

        // Output frequency and phase
        if (st_reg.ctrl.full_accum_clear_bit) begin
            st_next.freq_out = '0;
            st_next.pacc     = '0;
        end else begin
            st_next.freq_out = st_reg.act_ftw + st_reg.facc;
            st_next.pacc     = st_reg.pacc + st_reg.freq_out;
        end
        st_next.phase_out = st_reg.pacc[FW-1 -: PW] +
            ((bpsk && pins[0]) ? st_reg.act_ph2 : st_reg.act_ph1);

        // Read-back
        st_next.rdata = 8'h00;
        for (int i = 0; i < 6; i++) begin
            if (par_addr_i == `OFS_FTW + 6'(i)) begin
                st_next.rdata = st_reg.buf_ftw[FW-1-8*i -: 8];
            end
            if (par_addr_i == `OFS_STEP + 6'(i)) begin
                st_next.rdata = st_reg.buf_step[FW-1-8*i -: 8];
            end
            if (par_addr_i == `OFS_FRQ_RD + 6'(i)) begin
                st_next.rdata = st_reg.freq_out[FW-1-8*i -: 8];
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (par_addr_i == `OFS_UPD + 6'(i)) begin
                st_next.rdata = st_reg.buf_upd[UW-1-8*i -: 8];
            end
        end
        if (par_addr_i == `OFS_RAMP) begin
            st_next.rdata = {4'h0, st_reg.buf_ramp[RW-1 -: 4]};
        end else if (par_addr_i == `OFS_RAMP + 6'h01) begin
            st_next.rdata = st_reg.buf_ramp[15:8];
        end else if (par_addr_i == `OFS_RAMP + 6'h02) begin
            st_next.rdata = st_reg.buf_ramp[7:0];
        end else if (par_addr_i == `OFS_PH1) begin
            st_next.rdata = {2'h0, st_reg.buf_ph1[PW-1:8]};
        end else if (par_addr_i == `OFS_PH1 + 6'h01) begin
            st_next.rdata = st_reg.buf_ph1[7:0];
        end else if (par_addr_i == `OFS_PH2) begin
            st_next.rdata = {2'h0, st_reg.buf_ph2[PW-1:8]};
        end else if (par_addr_i == `OFS_PH2 + 6'h01) begin
            st_next.rdata = st_reg.buf_ph2[7:0];
        end else if (par_addr_i == `OFS_CTRL) begin
            st_next.rdata = st_reg.ctrl;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg          <= '0;
            st_reg.ctrl     <= ctrl_t'(`CTRL_RST);
            st_reg.buf_upd  <= `UPD_RST;
            st_reg.buf_ramp <= `RAMP_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign par_rdata_o = st_reg.rdata;
    assign update_o    = st_reg.upd_pin;
    assign update_oe_o = st_reg.ctrl.int_update;
    assign freq_word_o = st_reg.freq_out;
    assign phase_o     = st_reg.phase_out;

    // ==========================================================
    // Assertions
    a_update_apply: assert property (@(posedge clk_i) disable iff (!nrst_i)
        upd_evt |=> (st_reg.act_ftw == $past(st_reg.buf_ftw) &&
                     st_reg.act_step == $past(st_reg.buf_step)))
        else $error("update did not move buffers to active");
    a_no_early_apply: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !upd_evt |=> ($stable(st_reg.act_step) && $stable(st_reg.act_ramp)))
        else $error("active settings changed without update");
    a_clr1_clears: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_reg.clr1_pulse |=> (st_reg.facc == '0 &&
                               ($stable(st_reg.act_step) || $past(upd_evt))))
        else $error("frequency clear pulse did not clear accumulator");
    a_clr1_retrig: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (st_reg.ctrl.freq_accum_clear_bit && upd_evt) |=> st_reg.clr1_pulse ##1 st_reg.facc == '0)
        else $error("held frequency clear missed an update edge");
    a_full_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_reg.ctrl.full_accum_clear_bit [*2] |=> (st_reg.facc == '0 && st_reg.pacc == '0 &&
                                                   freq_word_o == '0))
        else $error("full clear did not hold accumulators at zero");
    a_step_add: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (tick && run && !st_reg.clr1_pulse) |=>
            (st_reg.facc == $past(st_reg.facc) + $past(st_reg.act_step)))
        else $error("step word not added on tick");
    a_hold_freeze: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (hold && !st_reg.clr1_pulse && chirp) |=> $stable(st_reg.facc))
        else $error("frequency moved during freeze");
    a_bpsk_select: assert property (@(posedge clk_i) disable iff (!nrst_i)
        bpsk |=> (phase_o == $past(st_reg.pacc[FW-1 -: PW]) +
                  ($past(pins[0]) ? $past(st_reg.act_ph2) : $past(st_reg.act_ph1))))
        else $error("keying pin picked the wrong phase offset");
    a_upd_pulse: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (st_reg.ctrl.int_update && int_evt) |=> st_reg.uhigh == `UPD_HIGH_CYC)
        else $error("internal update pulse width not loaded");
endmodule // chirp_ctrl

// ---- hw/pin_sync.sv ----
// Three-stage pin synchroniser; a level counts once the second and third stages agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_st_t;

    sync_st_t st_reg;
    sync_st_t st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = pin_i;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < W; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.lvl[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_o = st_reg.lvl;

    a_sync_agree: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (st_reg.s2 == st_reg.s3) |=> (level_o == $past(st_reg.s3)))
        else $error("synchronised level missed an agreed change");
endmodule // pin_sync

// ---- hw/ramp_tick.sv ----
// Ramp rate down-counter producing one tick every rate+1 running cycles
`timescale 1ns/1ps
module ramp_tick #(
    parameter int RW = 20
) (
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    input  wire logic [RW-1:0] rate_i,
    input  wire logic          run_i,
    output logic               tick_o
);
    typedef struct packed {
        logic [RW-1:0] cnt;
        logic          tick;
    } tick_st_t;

    tick_st_t st_reg;
    tick_st_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (run_i) begin
            if (st_reg.cnt == '0) begin
                st_next.tick = 1'b1;
                st_next.cnt  = rate_i;
            end else begin
                st_next.cnt  = st_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_o = st_reg.tick;

    a_tick_at_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (run_i && st_reg.cnt == '0) |=> (tick_o && st_reg.cnt == $past(rate_i)))
        else $error("ramp tick or reload missing at zero count");
    a_tick_frozen: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !run_i |=> ($stable(st_reg.cnt) && !tick_o))
        else $error("ramp counter moved while frozen");
    a_reload_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (run_i && st_reg.cnt != '0) |=> (st_reg.cnt == $past(st_reg.cnt) - 1'b1))
        else $error("ramp counter reloaded before reaching zero");
endmodule // ramp_tick

// ---- inc/chirp_cfg.svh ----
// Register offsets, field positions, reset values and timing counts of the chirp control
`ifndef CHIRP_CFG_SVH
`define CHIRP_CFG_SVH

// ==========================================================
// Register byte offsets (most significant byte at the lowest offset)
`define OFS_PH1        6'h00
`define OFS_PH2        6'h02
`define OFS_FTW        6'h04
`define OFS_STEP       6'h10
`define OFS_UPD        6'h16
`define OFS_RAMP       6'h1A
`define OFS_CTRL       6'h1F
`define OFS_FRQ_RD     6'h30

// ==========================================================
// Control byte fields
`define CTRL_CLR1_BIT  7
`define CTRL_CLR2_BIT  6
`define CTRL_MODE_LSB  1
`define CTRL_INTU_BIT  0
`define CTRL_RST       8'h01

// ==========================================================
// Reset values and timing
`define UPD_RST        32'h0000_0000
`define RAMP_RST       20'h0_0000
`define UPD_HIGH_CYC   4'h8

`endif

// ---- inc/chirp_pkg.sv ----
// Types shared by the chirp and phase keying control
package chirp_pkg;

    // ==========================================================
    // Operating mode codes
    typedef enum logic [2:0] {
        MODE_SINGLE = 3'h0,
        MODE_FSK    = 3'h1,
        MODE_RFSK   = 3'h2,
        MODE_CHIRP  = 3'h3,
        MODE_BPSK   = 3'h4
    } mode_t;

    // ==========================================================
    // Control byte layout
    typedef struct packed {
        logic       freq_accum_clear_bit;
        logic       full_accum_clear_bit;
        logic [1:0] spare;
        mode_t      mode;
        logic       int_update;
    } ctrl_t;

    // One captured host write
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } host_wr_t;

endpackage

// ---- tb/host_model.sv ----
// Host controller model: register writes, reads, update pulses and the mode pin
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] par_rdata_i,
    output logic      [5:0] par_addr_o,
    output logic      [7:0] par_wdata_o,
    output logic            par_wr_o,
    output logic            update_o,
    output logic            mode_pin_o
);
    initial begin
        par_addr_o  = 6'h3F;
        par_wdata_o = 8'hA5;
        par_wr_o    = 1'b0;
        update_o    = 1'b0;
        mode_pin_o  = 1'b0;
    end

    // ==========================================================
    // Strobe held 6 clocks, then data line inverted once released
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        par_addr_o  <= a;
        par_wdata_o <= d;
        par_wr_o    <= 1'b1;
        repeat (6) @(posedge clk_i);
        par_wr_o    <= 1'b0;
        par_wdata_o <= ~d;
        repeat (6) @(posedge clk_i);
    endtask

    // Most significant byte at the lowest offset
    task automatic wr_word(input logic [5:0] a, input logic [47:0] v, input int nb);
        for (int i = 0; i < nb; i++) begin
            wr(a + 6'(i), v[8*(nb-1-i) +: 8]);
        end
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_i);
        par_addr_o <= a;
        repeat (3) @(posedge clk_i);
        d = par_rdata_i;
    endtask

    // Issued only after all writes of a setting are done
    task automatic upd();
        @(posedge clk_i);
        update_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        update_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic pin(input logic v);
        @(posedge clk_i);
        mode_pin_o <= v;
        repeat (5) @(posedge clk_i);
    endtask
endmodule // host_model

// ---- tb/testbench.sv ----
// Self-checking testbench of the chirp and phase keying control
`timescale 1ns/1ps
`include "chirp_cfg.svh"
module testbench;
    import chirp_pkg::*;
    logic        clk_i  = 1'b0;
    logic        nrst_i = 1'b0;
    logic [5:0]  par_addr;
    logic [7:0]  par_wdata;
    logic        par_wr;
    logic [7:0]  par_rdata_o;
    logic        host_upd;
    logic        upd_pin;
    logic        update_o;
    logic        update_oe_o;
    logic        mode_pin;
    logic [47:0] freq_word_o;
    logic [13:0] phase_o;
    int          n_fail    = 0;
    int          cmp_count = 0;
    logic [31:0] seed      = 32'h4411F8A6;

    always #12.5 clk_i = ~clk_i;
    // Update pin level: the driver with its enable high owns the wire
    assign upd_pin = update_oe_o ? update_o : host_upd;

    host_model host (.clk_i(clk_i), .par_rdata_i(par_rdata_o), .par_addr_o(par_addr),
        .par_wdata_o(par_wdata), .par_wr_o(par_wr), .update_o(host_upd),
        .mode_pin_o(mode_pin));

    chirp_ctrl dut (.clk_i(clk_i), .nrst_i(nrst_i), .par_addr_i(par_addr),
        .par_wdata_i(par_wdata), .par_wr_i(par_wr), .par_rdata_o(par_rdata_o),
        .update_i(upd_pin), .update_o(update_o), .update_oe_o(update_oe_o),
        .mode_pin_i(mode_pin), .freq_word_o(freq_word_o), .phase_o(phase_o));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic complete_run();
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [47:0] e, input logic [47:0] a);
        cmp_count++;
        if (a !== e) begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask

    task automatic stall(input int c, input int lim);
        if (c >= lim) begin
            n_fail++;
            complete_run();
        end
    endtask

    // Cycles until the frequency word moves, and by how much
    task automatic wait_chg(input int lim, output int c, output logic [47:0] d);
        logic [47:0] p;
        p = freq_word_o;
        c = 0;
        while (freq_word_o === p && c < lim) begin
            @(negedge clk_i);
            c++;
        end
        stall(c, lim);
        d = freq_word_o - p;
    endtask

    task automatic wait_eq(input logic [47:0] e, input int lim);
        int c;
        c = 0;
        while (freq_word_o !== e && c < lim) begin
            @(negedge clk_i);
            c++;
        end
        chk(e, freq_word_o);
        stall(c, lim);
    endtask

    task automatic wait_lvl(input logic v, input int lim, output int c);
        c = 0;
        while (update_o !== v && c < lim) begin
            @(negedge clk_i);
            c++;
        end
        stall(c, lim);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [47:0] ftw;
        logic [47:0] stp;
        logic [47:0] d;
        logic [47:0] hold;
        logic [13:0] p1;
        logic [13:0] p2;
        logic [7:0]  r;
        int          c;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        chk(48'h1, 48'(update_oe_o));
        host.rd(`OFS_CTRL, r);
        chk(48'(`CTRL_RST), 48'(r));
        host.wr(`OFS_CTRL, 8'h06);
        @(negedge clk_i);
        chk(48'h0, 48'(update_oe_o));
        ftw = 48'({rnd(), rnd()});
        host.wr_word(`OFS_FTW, ftw, 6);
        host.rd(`OFS_FTW + 6'h05, r);
        chk(48'(ftw[7:0]), 48'(r));
        host.rd(6'h3F, r);
        chk(48'h0, 48'(r));
        host.wr_word(`OFS_RAMP, 48'h3, 3);
        // Up, flat, then down sweeps
        for (int k = 0; k < 3; k++) begin
            stp = (k == 1) ? 48'h0 : 48'(rnd() & 32'hFFFF) + 48'h1;
            if (k == 2) stp = -stp;
            host.wr_word(`OFS_STEP, stp, 6);
            @(negedge clk_i);
            if (k == 0) chk(48'h0, freq_word_o);
            host.upd();
            if (k == 1) begin
                hold = freq_word_o;
                repeat (30) @(negedge clk_i);
                chk(hold, freq_word_o);
            end else begin
                for (int w = 0; w < 3; w++) wait_chg(20, c, d);
                chk(stp, d);
                chk(48'h4, 48'(c));
            end
            if (k == 0) begin
                host.pin(1'b1);
                repeat (2) @(negedge clk_i);
                hold = freq_word_o;
                repeat (20) @(negedge clk_i);
                chk(hold, freq_word_o);
                // New rate applied while frozen; old count must finish first
                host.wr_word(`OFS_RAMP, 48'h9, 3);
                host.upd();
                chk(hold, freq_word_o);
                host.pin(1'b0);
                wait_chg(20, c, d);
                chk(stp, d);
                chk(48'h1, 48'(c <= 6));
                wait_chg(20, c, d);
                chk(48'hA, 48'(c));
                host.wr_word(`OFS_RAMP, 48'h3, 3);
            end
        end
        // Frequency clear, single and retriggered by update
        host.wr_word(`OFS_RAMP, 48'hC8, 3);
        host.upd();
        // Start just after a tick so the clear lands far from the next one
        wait_chg(300, c, d);
        chk(stp, d);
        host.wr(`OFS_CTRL, 8'h86);
        wait_eq(ftw, 30);
        wait_chg(300, c, d);
        chk(stp, d);
        host.upd();
        wait_eq(ftw, 30);
        // Full clear; new start and flat slope kept for the resume
        host.wr(`OFS_CTRL, 8'h46);
        wait_eq(48'h0, 30);
        ftw = 48'({rnd(), rnd()});
        host.wr_word(`OFS_FTW, ftw, 6);
        host.wr_word(`OFS_STEP, 48'h0, 6);
        host.upd();
        chk(48'h0, freq_word_o);
        host.wr(`OFS_CTRL, 8'h06);
        wait_eq(ftw, 30);
        // Phase keying with accumulators held at zero
        p1 = 14'(rnd());
        p2 = 14'(rnd());
        host.wr(`OFS_CTRL, 8'h48);
        host.wr_word(`OFS_PH1, 48'(p1), 2);
        host.wr_word(`OFS_PH2, 48'(p2), 2);
        host.upd();
        host.pin(1'b0);
        @(negedge clk_i);
        chk(48'(p1), 48'(phase_o));
        host.pin(1'b1);
        @(negedge clk_i);
        chk(48'(p2), 48'(phase_o));
        // Internal update every (5+1)*2 clocks, high for 8
        host.wr_word(`OFS_UPD, 48'h5, 4);
        host.wr(`OFS_CTRL, 8'h49);
        wait_lvl(1'b0, 40, c);
        wait_lvl(1'b1, 40, c);
        wait_lvl(1'b0, 40, c);
        chk(48'h8, 48'(c));
        wait_lvl(1'b1, 40, c);
        chk(48'h4, 48'(c));
        // Single tone: only phase offset one is rewritten, pin ignored
        host.wr(`OFS_CTRL, 8'h40);
        p1 = 14'(rnd());
        host.wr_word(`OFS_PH1, 48'(p1), 2);
        host.upd();
        @(negedge clk_i);
        chk(48'(p1), 48'(phase_o));
        // Sawtooth: held frequency clear restarted by the internal update
        host.pin(1'b0);
        host.wr_word(`OFS_STEP, stp, 6);
        host.wr_word(`OFS_RAMP, 48'h1, 3);
        host.wr(`OFS_CTRL, 8'h87);
        wait_eq(ftw, 30);
        wait_chg(300, c, d);
        chk(stp, d);
        wait_eq(ftw, 30);
        complete_run();
    end
endmodule // testbench
